//--- design/srfd_rx.sv
// Purpose: receive framer, 8B/10B decoder and ready strobe of a serial link
// Assumes: serial_in carries one recovered bit per clock, first bit a
// Notes:   data and flag outputs change together at the byte clock rising edge, where ready_n falls
`include "srfd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module srfd_rx
  import srfd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       serial_in,
  input  wire logic       reframe_enable,
  input  wire logic [1:0] mode_sel,
  input  wire logic       sink_ready,
  output logic [7:0]      parallel_data_out,
  output logic            special_char_flag,
  output logic            violation_flag,
  output logic            ready_n,
  output logic            recovered_byte_clock,
  output logic            rx_buf_ready
);

  // ==========================================================
  // code tables
  // 6b block to {valid, EDCBA}
  function automatic logic [5:0] dec6(input logic [5:0] c);
    case (c)
      6'h27, 6'h18: dec6 = 6'h20;
      6'h1D, 6'h22: dec6 = 6'h21;
      6'h2D, 6'h12: dec6 = 6'h22;
      6'h31:        dec6 = 6'h23;
      6'h35, 6'h0A: dec6 = 6'h24;
      6'h29:        dec6 = 6'h25;
      6'h19:        dec6 = 6'h26;
      6'h38, 6'h07: dec6 = 6'h27;
      6'h39, 6'h06: dec6 = 6'h28;
      6'h25:        dec6 = 6'h29;
      6'h15:        dec6 = 6'h2A;
      6'h34:        dec6 = 6'h2B;
      6'h0D:        dec6 = 6'h2C;
      6'h2C:        dec6 = 6'h2D;
      6'h1C:        dec6 = 6'h2E;
      6'h17, 6'h28: dec6 = 6'h2F;
      6'h1B, 6'h24: dec6 = 6'h30;
      6'h23:        dec6 = 6'h31;
      6'h13:        dec6 = 6'h32;
      6'h32:        dec6 = 6'h33;
      6'h0B:        dec6 = 6'h34;
      6'h2A:        dec6 = 6'h35;
      6'h1A:        dec6 = 6'h36;
      6'h3A, 6'h05: dec6 = 6'h37;
      6'h33, 6'h0C: dec6 = 6'h38;
      6'h26:        dec6 = 6'h39;
      6'h16:        dec6 = 6'h3A;
      6'h36, 6'h09: dec6 = 6'h3B;
      6'h0E:        dec6 = 6'h3C;
      6'h2E, 6'h11: dec6 = 6'h3D;
      6'h1E, 6'h21: dec6 = 6'h3E;
      6'h2B, 6'h14: dec6 = 6'h3F;
      6'h0F, 6'h30: dec6 = 6'h3C;
      default:      dec6 = 6'h00;
    endcase
  endfunction

  // 4b block to {valid, alternate seven, HGF}
  function automatic logic [4:0] dec4(input logic [3:0] c);
    case (c)
      4'hB, 4'h4: dec4 = 5'h10;
      4'h9:       dec4 = 5'h11;
      4'h5:       dec4 = 5'h12;
      4'hC, 4'h3: dec4 = 5'h13;
      4'hD, 4'h2: dec4 = 5'h14;
      4'hA:       dec4 = 5'h15;
      4'h6:       dec4 = 5'h16;
      4'hE, 4'h1: dec4 = 5'h17;
      4'h7, 4'h8: dec4 = 5'h1F;
      default:    dec4 = 5'h00;
    endcase
  endfunction

  // ==========================================================
  // state and mode
  srfd_state_s s_q;
  srfd_state_s s_d;
  srfd_mode_e  mode;
  logic [9:0]  raw;
  logic [9:0]  byp_word;

  always_comb begin
    case (mode_sel)
      `SRFD_MODE_PIN_BYP:  mode = SRFD_BYP;
      `SRFD_MODE_PIN_TEST: mode = SRFD_TEST;   // test behaves as encoded
      default:             mode = SRFD_ENC;
    endcase
  end

  assign raw = {s_q.shreg[8:0], serial_in};

  // bypass: a to special, b..h,i to data, j to violation
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_byp
      assign byp_word[gi] = raw[8 - gi];
    end
  endgenerate
  assign byp_word[8] = raw[9];
  assign byp_word[9] = raw[0];

  // ==========================================================
  // decoder
  logic [5:0] d6;
  logic [4:0] d4;
  logic [3:0] f4;
  logic       k28;
  logic       isk;
  logic       bad;
  logic       rd1;
  logic       rd2;
  logic       rd_err;
  logic       comma;
  logic [9:0] enc_word;
  int         o6;
  int         o4;

  always_comb begin
    k28      = (raw[9:4] == 6'h0F) || (raw[9:4] == 6'h30);
    f4       = (raw[9:4] == 6'h30) ? ~raw[3:0] : raw[3:0];
    d6       = dec6(raw[9:4]);
    d4       = dec4(f4);
    o6       = $countones(raw[9:4]);
    o4       = $countones(raw[3:0]);
    comma    = (raw == `SRFD_COMMA_NEG) || (raw == `SRFD_COMMA_POS);
    isk      = k28 || (d4[3] && (d6[4:0] == 5'h17 || d6[4:0] == 5'h1B
                                 || d6[4:0] == 5'h1D || d6[4:0] == 5'h1E));
    bad      = !d6[5] || !d4[4] || (d4[3] && !isk && !(d6[4:0] == 5'h0B
               || d6[4:0] == 5'h0D || d6[4:0] == 5'h0E || d6[4:0] == 5'h11
               || d6[4:0] == 5'h12 || d6[4:0] == 5'h14));
    // neutral blocks keep the running value; errors still update it
    // block disparity against the running value
    rd1      = (o6 != 3) ? (o6 > 3) : s_q.rd;
    rd2      = (o4 != 2) ? (o4 > 2) : rd1;
    rd_err   = (o6 == 2 && !s_q.rd) || (o6 == 4 && s_q.rd)
               || (o4 == 1 && !rd1) || (o4 == 3 && rd1)
               || (o4 == 2 && o6 == 3 && 1'b0);
    // sent violations take the same path as noise errors
    if (bad) begin
      enc_word = {2'h3, `SRFD_VIO_UNASSIGNED};
    end else if (rd_err && raw == `SRFD_COMMA_NEG && s_q.rd) begin
      enc_word = {2'h3, `SRFD_VIO_K285_RDPOS};
    end else if (rd_err && raw == `SRFD_COMMA_POS && !s_q.rd) begin
      enc_word = {2'h3, `SRFD_VIO_K285_RDNEG};
    end else if (rd_err) begin
      enc_word = {2'h3, `SRFD_VIO_WRONG_RD};
    end else if (isk && k28 && d4[2:0] == 3'h7 && s_q.pend_valid
                 && s_q.pend_word == {2'h1, `SRFD_CODE_K281}) begin
      enc_word = {2'h1, `SRFD_CODE_K287_K281};
    end else if (isk && k28 && d4[2:0] == 3'h7 && s_q.pend_valid
                 && s_q.pend_word == {2'h1, `SRFD_CODE_K285}) begin
      enc_word = {2'h1, `SRFD_CODE_K287_K285};
    end else if (isk && k28) begin
      enc_word = {2'h1, 5'h00, d4[2:0]};
    end else if (isk) begin
      enc_word = {2'h1, 6'h02, d6[2], d6[1]};   // K27 to 09, K29 to 0A, K23 and K30 both to 0B
    end else begin
      enc_word = {2'h0, d4[2:0], d6[4:0]};
    end
  end

  // ==========================================================
  // framer, pending stage, buffer and output stage
  logic        char_done;
  logic        usable;
  logic        push;
  logic        pop;
  logic [10:0] head;

  always_comb begin
    s_d          = s_q;
    s_d.shreg    = raw;
    s_d.re_prev  = reframe_enable;
    // comma search looks at the ten newest bits, not the counter, so a
    // boundary anywhere in the stream is found within one character
    // comma realigns only while reframing allowed, in every mode
    char_done    = (s_q.bit_cnt == `SRFD_BIT_LAST)
                   || (reframe_enable && comma);
    s_d.bit_cnt  = char_done ? 4'h0 : s_q.bit_cnt + 4'h1;

    // fill decided when the next character shows up
    usable = (mode == SRFD_BYP) ? s_q.pend_comma
                                : !(s_q.pend_comma && comma);
    // the pending character is lost if the next one is done while the buffer is full;
    // rx_buf_ready low tells the far side that the buffer is full
    push   = char_done && s_q.pend_valid && (s_q.buf_cnt != 2'h2);
    rx_buf_ready = (s_q.buf_cnt != 2'h2);
    pop    = (s_q.buf_cnt != 2'h0) && sink_ready && (s_q.ph == `SRFD_BIT_LAST);
    head   = s_q.buf_mem[s_q.buf_rp];

    if (char_done) begin
      s_d.pend_valid = 1'b1;
      s_d.pend_word  = (mode == SRFD_BYP) ? byp_word : enc_word;
      s_d.pend_comma = comma;
      s_d.pend_force = s_q.hunt && reframe_enable && comma;
      s_d.pend_hunt  = s_q.hunt && !(reframe_enable && comma);
      s_d.rd         = rd2;
    end

    // search ends on a framed comma; a new rising edge wins
    if (char_done && reframe_enable && comma) begin
      s_d.hunt = 1'b0;
    end
    if (reframe_enable && !s_q.re_prev) begin
      s_d.hunt = 1'b1;
    end

    // data keeps moving while hunting; only the strobe bit is dropped
    if (push) begin
      s_d.buf_mem[s_q.buf_wp] = {s_q.pend_force || (usable && !s_q.pend_hunt),
                                 s_q.pend_word};
      s_d.buf_wp              = ~s_q.buf_wp;
    end
    if (pop) begin
      s_d.buf_rp = ~s_q.buf_rp;
    end
    s_d.buf_cnt = s_q.buf_cnt + {1'b0, push} - {1'b0, pop};

    // a new search also hides strobes of words already queued,
    // since those were framed before the search began
    if (reframe_enable && !s_q.re_prev) begin
      s_d.pend_hunt         = 1'b1;
      s_d.buf_mem[0][10]    = 1'b0;
      s_d.buf_mem[1][10]    = 1'b0;
    end

    // byte clock and strobe share one phase counter so they cannot drift
    // byte-rate output frame, word and strobe loaded on one edge
    s_d.ph = (s_q.ph == `SRFD_BIT_LAST) ? 4'h0 : s_q.ph + 4'h1;
    if (pop) begin
      s_d.out_word   = head[9:0];
      s_d.out_strobe = head[10];
    end else if (s_q.ph == `SRFD_BIT_LAST) begin
      s_d.out_strobe = 1'b0;  // stalled frame repeats the word without a strobe
    end
    s_d.rdy_n   = !(s_d.out_strobe && s_d.ph < 4'(`SRFD_RDY_LOW_CYC));
    s_d.byte_ck = (s_d.ph < `SRFD_BYTE_CK_HIGH);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.rdy_n   <= 1'b1;
      // phase 0 has the byte clock high; a low reset value would give
      // a short first high phase after release
      s_q.byte_ck <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops except rx_buf_ready, decoded from buf_cnt
  assign parallel_data_out    = s_q.out_word[7:0];
  assign special_char_flag    = s_q.out_word[8];
  assign violation_flag       = s_q.out_word[9];
  assign ready_n              = s_q.rdy_n;
  assign recovered_byte_clock = s_q.byte_ck;

endmodule

`default_nettype wire

//--- design/srfd_defs.svh
// Purpose: constants of the serial receiver framer and decoder
// Assumes: one recovered bit per clock at 50 MHz
// Notes:   included by the package and the receiver module
`ifndef SRFD_DEFS_SVH
`define SRFD_DEFS_SVH

// ==========================================================
// character and framing
`define SRFD_CHAR_BITS      10
`define SRFD_BIT_LAST       4'h9
`define SRFD_COMMA_NEG      10'h0FA
`define SRFD_COMMA_POS      10'h305

// ==========================================================
// ready strobe timing
`define SRFD_RDY_LOW_PCT    60
`define SRFD_RDY_LOW_CYC    ((`SRFD_CHAR_BITS * `SRFD_RDY_LOW_PCT) / 100)
`define SRFD_BYTE_CK_HIGH   4'h5

// ==========================================================
// decoded output codes
`define SRFD_CODE_K287_K281 8'h27
`define SRFD_CODE_K287_K285 8'h47
`define SRFD_CODE_K281      8'h01
`define SRFD_CODE_K285      8'h05
`define SRFD_VIO_UNASSIGNED 8'hE0
`define SRFD_VIO_K285_RDPOS 8'hE1
`define SRFD_VIO_K285_RDNEG 8'hE2
`define SRFD_VIO_WRONG_RD   8'hE4

// ==========================================================
// mode pin encoding
`define SRFD_MODE_PIN_ENC   2'h0
`define SRFD_MODE_PIN_BYP   2'h1
`define SRFD_MODE_PIN_TEST  2'h2

`endif

//--- design/srfd_pkg.sv
// Purpose: types of the serial receiver framer and decoder
// Assumes: srfd_defs.svh holds the numbers
// Notes:   state of the receiver is one packed struct
`include "srfd_defs.svh"

package srfd_pkg;

  // ==========================================================
  // receive modes, one-hot
  typedef enum logic [2:0] {
    SRFD_ENC  = 3'h1,
    SRFD_BYP  = 3'h2,
    SRFD_TEST = 3'h4
  } srfd_mode_e;

  // ==========================================================
  // whole receiver state; words are {violation, special, data[7:0]}
  typedef struct packed {
    logic [3:0]       bit_cnt;
    logic [9:0]       shreg;
    logic             re_prev;
    logic             hunt;
    logic             rd;
    logic             pend_valid;
    logic [9:0]       pend_word;
    logic             pend_comma;
    logic             pend_force;
    logic             pend_hunt;
    logic [1:0][10:0] buf_mem;
    logic             buf_wp;
    logic             buf_rp;
    logic [1:0]       buf_cnt;
    logic [3:0]       ph;
    logic [9:0]       out_word;
    logic             out_strobe;
    logic             rdy_n;
    logic             byte_ck;
  } srfd_state_s;

endpackage

//--- verif/srfd_link_model.sv
// Purpose: remote serializer model feeding the receiver
// Assumes: bits leave msb first, one per falling edge
// Notes:   idle link carries fill commas of alternating disparity
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// serial transmitter
module srfd_link_model (
  input  wire logic clock,
  input  wire logic rst_n,
  output logic      serial_out
);
  logic [14:0] q[$];
  logic [14:0] e;
  logic [9:0]  sh;
  int          n;
  logic        rd;

  initial begin
    serial_out = 1'b0;
    n = 0;
    rd = 1'b0;
  end

  // entry {pick by disparity, length, bits}; commas give transitions
  always @(negedge clock) begin
    if (!rst_n) begin
      n = 0;
      rd = 1'b0;
    end else begin
      if (n == 0) begin
        if (q.size() == 0) q.push_back(15'h68FA);
        e = q.pop_front();
        n = e[13:10];
        sh = (e[14] && rd) ? ~e[9:0] : e[9:0];
        if (e[14] && $countones(e[9:0]) != 5) rd = ~rd;
      end
      serial_out = sh[9];
      sh = sh << 1;
      n = n - 1;
    end
  end

  task automatic put(input logic [3:0] len, input logic [9:0] bits);
    q.push_back({1'b0, len, bits});
  endtask

  // sent in the form that suits running disparity
  task automatic pick(input logic [9:0] bits);
    q.push_back({1'b1, 4'hA, bits});
  endtask
endmodule

`default_nettype wire

//--- verif/srfd_rx_assertions.sv
// Purpose: port checker of the receiver
// Assumes: mode only changes under reset
// Notes:   words read as {violation, special, data}
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// checker
module srfd_rx_checker (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [1:0] mode_sel,
  input wire logic       sink_ready,
  input wire logic [7:0] parallel_data_out,
  input wire logic       special_char_flag,
  input wire logic       violation_flag,
  input wire logic       ready_n,
  input wire logic       recovered_byte_clock
);
  logic [9:0] w;
  logic       enc;
  assign w = {violation_flag, special_char_flag, parallel_data_out};
  assign enc = (mode_sel != 2'h1);

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  strobe_width_a: assert property (
    $fell(ready_n) |=> !ready_n [*5] ##1 ready_n) else $error("strobe width");
  byte_clock_a: assert property (
    $rose(recovered_byte_clock) |-> recovered_byte_clock [*5] ##1
    !recovered_byte_clock [*5] ##1 recovered_byte_clock) else $error("byte clock");
  outs_aligned_a: assert property (
    !$stable(w) |-> $rose(recovered_byte_clock)) else $error("outputs off clock");
  strobe_aligned_a: assert property (
    $fell(ready_n) |-> $rose(recovered_byte_clock)) else $error("strobe off clock");
  stall_hold_a: assert property (
    $rose(recovered_byte_clock) && !$past(sink_ready) |-> ready_n && $stable(w))
    else $error("stall not held");
  bypass_comma_a: assert property (
    !enc && $fell(ready_n) |-> (w == 10'h0BE || w == 10'h341)) else $error("bypass strobe");
  special_range_a: assert property (
    enc && special_char_flag && !violation_flag |-> (parallel_data_out <= 8'h0B ||
    parallel_data_out == 8'h27 || parallel_data_out == 8'h47)) else $error("special code");
  violation_code_a: assert property (
    enc && violation_flag |-> special_char_flag &&
    parallel_data_out inside {8'hE0, 8'hE1, 8'hE2, 8'hE4}) else $error("violation code");
endmodule

bind srfd_rx srfd_rx_checker u_srfd_rx_checker (.clock(clock), .rst_n(rst_n),
  .mode_sel(mode_sel), .sink_ready(sink_ready), .parallel_data_out(parallel_data_out),
  .special_char_flag(special_char_flag), .violation_flag(violation_flag),
  .ready_n(ready_n), .recovered_byte_clock(recovered_byte_clock));

`default_nettype wire

//--- verif/srfd_rx_tb.sv
// Purpose: self-checking bench of the receiver
// Assumes: link model sends fill commas when idle
// Notes:   words logged at byte clock rise, strobed words kept apart
`timescale 1ns/1ps
`default_nettype none

module srfd_rx_tb;
  logic       clock, rst_n, serial_in, reframe_enable, sink_ready;
  logic [1:0] mode_sel;
  logic [7:0] parallel_data_out;
  logic       special_char_flag, violation_flag, ready_n, recovered_byte_clock, rx_buf_ready;
  logic [9:0] w, e1, got[$], shown[$];
  logic       rdy_q, ck_q, full_seen, found;
  int         error_cnt, num_checks, n0, i;
  assign w = {violation_flag, special_char_flag, parallel_data_out};

  srfd_rx u_srfd_rx (.clock(clock), .rst_n(rst_n), .serial_in(serial_in),
    .reframe_enable(reframe_enable), .mode_sel(mode_sel), .sink_ready(sink_ready),
    .parallel_data_out(parallel_data_out), .special_char_flag(special_char_flag),
    .violation_flag(violation_flag), .ready_n(ready_n),
    .recovered_byte_clock(recovered_byte_clock), .rx_buf_ready(rx_buf_ready));
  srfd_link_model u_srfd_link_model (.clock(clock), .rst_n(rst_n), .serial_out(serial_in));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ==========================================================
  // capture at byte clock rise, and once at each falling edge of ready_n
  always @(negedge clock) begin
    if (recovered_byte_clock && !ck_q) shown.push_back(w);
    if (!ready_n && rdy_q) got.push_back(w);
    if (!rx_buf_ready) full_seen = 1'b1;
    rdy_q = ready_n;
    ck_q = recovered_byte_clock;
  end

  task automatic check(input logic [9:0] act, input logic [9:0] exp);
    num_checks++;
    if (act !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t mismatch got %h want %h", $time, act, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask

  task automatic do_reset(input logic [1:0] m);
    rst_n <= 1'b0;
    reframe_enable <= 1'b0;
    mode_sel <= m;
    cyc(16);
    rst_n <= 1'b1;
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // bounded wait for strobed words
  task automatic wait_got(input int k);
    for (i = 0; i < 400 && got.size() < k; i++) cyc(1);
    if (got.size() < k) begin
      error_cnt++;
      $display("[FAIL] %0t strobe timeout", $time);
      close_out();
    end
  endtask

  // ==========================================================
  // scenarios
  initial begin
    {rst_n, reframe_enable, mode_sel} = 4'h0;
    sink_ready = 1'b1;
    {rdy_q, ck_q, full_seen} = 3'h4;
    error_cnt = 0;
    num_checks = 0;
    u_srfd_link_model.put(4'h3, 10'h2A5);
    do_reset(2'h0);
    cyc(60);
    check(10'(w !== 10'h105), 10'h1);
    reframe_enable <= 1'b1;
    @(posedge clock);
    // framing comma follows misaligned words, so its disparity check sees
    // a stale running value unless the current comma ends at this edge
    e1 = (u_srfd_link_model.n == 0) ? 10'h105 : u_srfd_link_model.rd ? 10'h3E1 : 10'h3E2;
    cyc(3);
    @(posedge clock);
    got.delete();
    cyc(120);
    check(10'(got.size()), 10'h1);
    check(got[0], e1);
    check(w, 10'h105);
    // stall: buffer must fill and outputs hold
    sink_ready <= 1'b0;
    cyc(1);
    n0 = shown.size();
    e1 = w;
    cyc(60);
    found = 1'b1;
    for (i = n0; i < shown.size(); i++) if (shown[i] !== e1) found = 1'b0;
    check(10'(found), 10'h1);
    check(10'(full_seen), 10'h1);
    sink_ready <= 1'b1;
    cyc(30);
    check(10'(shown.size() > n0), 10'h1);
    // last comma, K28.7, data, wrong-disparity comma, unassigned
    @(posedge clock);
    e1 = u_srfd_link_model.rd ? 10'h3E2 : 10'h3E1;
    u_srfd_link_model.pick(10'h0FA);
    u_srfd_link_model.pick(10'h0F8);
    u_srfd_link_model.put(4'hA, 10'h2AA);
    u_srfd_link_model.put(4'hA, (e1 == 10'h3E1) ? 10'h0FA : 10'h305);
    u_srfd_link_model.put(4'hA, 10'h000);
    got.delete();
    wait_got(5);
    check(got[0], 10'h105);
    check(got[1], 10'h147);
    check(got[2], 10'h0B5);
    check(got[3], e1);
    check(got[4], 10'h3E0);
    // bypass after a second reset
    do_reset(2'h1);
    reframe_enable <= 1'b1;
    cyc(40);
    @(posedge clock);
    u_srfd_link_model.put(4'hA, 10'h2AA);
    n0 = shown.size();
    got.delete();
    cyc(160);
    found = 1'b0;
    for (i = n0; i < shown.size(); i++) if (shown[i] === 10'h1AA) found = 1'b1;
    check(10'(found), 10'h1);
    check(10'(got.size() >= 13), 10'h1);
    foreach (got[j]) check(10'(got[j] === 10'h0BE || got[j] === 10'h341), 10'h1);
    // test mode decodes as encoded
    do_reset(2'h2);
    reframe_enable <= 1'b1;
    got.delete();
    wait_got(1);
    // first framed comma follows a stale-bit word that leaves disparity positive
    check(got[0], 10'h3E1);
    close_out();
  end
endmodule

`default_nettype wire
